// ===== hw/pif_pkg.sv
/*
 * Shared constants for the protection-information formatter: protection
 * types, command lengths, phase and state codes and the PI byte count and fill.
 * Assumes a single 100 MHz clock domain and a byte-wide data path.
 */
package pif_pkg;

    // Protection-information bytes that follow each logical block that carries PI.
    localparam int        PI_BYTES      = 8;
    // Fill byte of device-generated protection information.
    localparam logic [7:0] PI_FILL      = 8'hFF;
    // Logical block size after reset, in bytes.
    localparam logic [15:0] DEF_BLK_LEN = 16'h0200;

    // Protection type codes.
    localparam logic [1:0] PI_TYPE0 = 2'h0;
    localparam logic [1:0] PI_TYPE1 = 2'h1;
    localparam logic [1:0] PI_TYPE2 = 2'h2;
    localparam logic [1:0] PI_TYPE3 = 2'h3;

    // Command descriptor block length codes.
    localparam logic [1:0] CDB_10    = 2'h0;
    localparam logic [1:0] CDB_16    = 2'h1;
    localparam logic [1:0] CDB_32    = 2'h2;
    localparam logic [1:0] CDB_OTHER = 2'h3;

    // Width of the read or write protect field.
    localparam int PROT_W = 3;

    // Phases of one block stream.
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_DATA = 2'b01,
        PH_PI   = 2'b10
    } pif_phase_t;

    // Command states of the top level.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01
    } pif_state_t;

endpackage

// ===== hw/pif_cmd_check.sv
/*
 * Command screen: decides from the formatted type, the command length and
 * the protect field whether a command is taken and where PI bytes travel.
 * Assumes the caller registers the results; the logic here is combinational.
 */
`timescale 1ns/10ps
module pif_cmd_check (
    input  wire logic [1:0]                 i_pi_type,
    input  wire logic [1:0]                 i_cdb,
    input  wire logic [pif_pkg::PROT_W-1:0] i_protect,
    output logic                            o_ok,
    output logic                            o_host_pi,
    output logic                            o_media_pi,
    output logic                            o_check_en
);
    import pif_pkg::*;

    wire prot_set = |i_protect;
    wire short_cdb = (i_cdb == CDB_10) | (i_cdb == CDB_16);
    wire long_cdb  = (i_cdb == CDB_32);

    // R4 type 0 legacy
    // R14 protect refused
    wire ok_t0 = short_cdb & ~prot_set;
    // R5 type1 lengths
    wire ok_t1 = short_cdb;
    // R8 type2 long
    // R9 short needs zero
    wire ok_t2 = long_cdb | (short_cdb & ~prot_set);

    // Acceptance by type; type 3 is never formatted and so refuses all.
    assign o_ok = (i_pi_type == PI_TYPE0) ? ok_t0 :
                  (i_pi_type == PI_TYPE1) ? ok_t1 :
                  (i_pi_type == PI_TYPE2) ? ok_t2 : 1'b0;

    // R1 media holds PI
    assign o_media_pi = (i_pi_type == PI_TYPE1) | (i_pi_type == PI_TYPE2);
    // R7 host PI bytes
    assign o_host_pi  = o_media_pi & prot_set;
    // R6 checks follow protect
    assign o_check_en = o_media_pi & prot_set;

endmodule

// ===== hw/pif_blk_stream.sv
/*
 * One-direction block stream: moves logical blocks of data bytes and,
 * per block, passes, strips or generates the eight PI bytes.
 * Assumes the caller starts it only when idle and with a nonzero count.
 */
`timescale 1ns/10ps
module pif_blk_stream #(
    parameter int LEN_W = 16,
    parameter int CNT_W = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic             i_start,
    input  wire logic [LEN_W-1:0] i_blk_len,
    input  wire logic [CNT_W-1:0] i_blocks,
    input  wire logic             i_in_pi,
    input  wire logic             i_out_pi,
    input  wire logic             i_in_valid,
    input  wire logic [7:0]       i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [7:0]            o_out_data,
    input  wire logic             i_out_ready,
    output logic                  o_done
);
    import pif_pkg::*;

    pif_phase_t       phase_reg, phase_next;
    logic [LEN_W-1:0] cnt_reg, cnt_next, len_reg;
    logic [CNT_W-1:0] left_reg, left_next;
    logic             in_pi_reg, out_pi_reg, done_next;

    // Phase decode and the byte step of this cycle.
    wire idle_ph   = (phase_reg == PH_IDLE);
    wire data_ph   = (phase_reg == PH_DATA);
    wire pi_ph     = (phase_reg == PH_PI);
    wire gen_ph    = pi_ph & ~in_pi_reg;
    wire step      = gen_ph ? ~o_out_valid : (o_in_ready & i_in_valid);
    wire emit      = step & (data_ph | out_pi_reg);
    wire any_pi    = in_pi_reg | out_pi_reg;
    wire data_last = (cnt_reg == len_reg - LEN_W'(1));
    wire pi_last   = (cnt_reg == LEN_W'(PI_BYTES - 1));
    wire full_next = (o_out_valid & ~i_out_ready) | emit;
    wire in_pi_now = idle_ph ? i_in_pi : in_pi_reg;
    wire want_in   = (phase_next == PH_DATA) | ((phase_next == PH_PI) & in_pi_now);
    // R10 device fills PI
    wire [7:0] emit_data = gen_ph ? PI_FILL : i_in_data;

    // R1 block then PI
    always_comb begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        left_next  = left_reg;
        done_next  = 1'b0;
        case (phase_reg)
            PH_IDLE: begin
                if (i_start) begin
                    phase_next = PH_DATA;
                    cnt_next   = '0;
                    left_next  = i_blocks;
                end
            end
            PH_DATA: begin
                if (step & data_last & any_pi) begin
                    phase_next = PH_PI;
                    cnt_next   = '0;
                end else if (step & data_last) begin
                    cnt_next   = '0;
                    left_next  = left_reg - CNT_W'(1);
                    phase_next = (left_reg == CNT_W'(1)) ? PH_IDLE : PH_DATA;
                    done_next  = (left_reg == CNT_W'(1));
                end else if (step) begin
                    cnt_next = cnt_reg + LEN_W'(1);
                end
            end
            PH_PI: begin
                if (step & pi_last) begin
                    cnt_next   = '0;
                    left_next  = left_reg - CNT_W'(1);
                    phase_next = (left_reg == CNT_W'(1)) ? PH_IDLE : PH_DATA;
                    done_next  = (left_reg == CNT_W'(1));
                end else if (step) begin
                    cnt_next = cnt_reg + LEN_W'(1);
                end
            end
            default: begin
                phase_next = PH_IDLE;
            end
        endcase
    end

    // State, holding register and registered input ready.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_reg   <= PH_IDLE;
            cnt_reg     <= '0;
            left_reg    <= '0;
            len_reg     <= LEN_W'(DEF_BLK_LEN);
            in_pi_reg   <= 1'b0;
            out_pi_reg  <= 1'b0;
            o_in_ready  <= 1'b0;
            o_out_valid <= 1'b0;
            o_out_data  <= 8'h00;
            o_done      <= 1'b0;
        end else if (i_ce) begin
            phase_reg   <= phase_next;
            cnt_reg     <= cnt_next;
            left_reg    <= left_next;
            o_in_ready  <= want_in & ~full_next;
            o_out_valid <= full_next;
            o_done      <= done_next;
            if (emit) begin
                o_out_data <= emit_data;
            end
            if (idle_ph & i_start) begin
                len_reg    <= i_blk_len;
                in_pi_reg  <= i_in_pi;
                out_pi_reg <= i_out_pi;
            end
        end
    end

    // R10 generated fill
    gen_fill_out_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        (i_ce & gen_ph & ~o_out_valid) |=> (o_out_valid & o_out_data == PI_FILL))
        else $error("generated PI byte not emitted as fill");
    stripped_pi_silent_a: assert property (@(posedge i_clk) disable iff (i_rst) // R10
        (i_ce & pi_ph & ~out_pi_reg & ~o_out_valid) |=> ~o_out_valid)
        else $error("stripped PI byte reached the output");

endmodule

// ===== hw/pif_pi_formatter.sv
/*
 * Protection-information formatter top: holds the formatted type and block
 * size, screens commands and runs the write (host to media) and read (media
 * to host) byte streams with PI appended, passed or stripped per block.
 * Assumes one 100 MHz clock, synchronous inputs and a caller that frees the
 * media for wiping when a format is announced.
 */
`timescale 1ns/10ps

// Contract
// R1 - With PI, each block is stored as 512 data bytes plus 8 PI bytes. The code stores the formatted block length, 512 after reset.
// R2 - Reported block count does not shrink when formatted with PI.
// R3 - PI formatting works with every supported logical block size.
// R4 - Type 0 keeps no PI bytes and acts as legacy unprotected target.
// R5 - Type 1 takes 10 and 16 byte commands, refuses 32 byte ones.
// R6 - Type 1 picks its checks from each command's protect fields.
// R7 - Types 1 and 2 with nonzero protect carry eight PI bytes per block.
// R8 - Type 2 accepts 32 byte commands with their checking control fields.
// R9 - Type 2 accepts 10 and 16 byte commands only with zero protect.
// R10 - Zero-protect type 2 writes get device PI, never returned on reads.
// R11 - Type 3 is unsupported and can never be formatted.
// R12 - One type at a time; changing it formats and wipes all data.
// R13 - Current type is reported for the long read capacity answer.
// R14 - Type 0 rejects commands whose protect field is nonzero.
module pif_pi_formatter #(
    parameter int          LEN_W      = 16,
    parameter int          CNT_W      = 16,
    parameter int          CAP_W      = 32,
    parameter logic [31:0] CAP_BLOCKS = 32'h0010_0000
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_ce,
    input  wire logic                       i_fmt_req,
    input  wire logic [1:0]                 i_fmt_type,
    input  wire logic [LEN_W-1:0]           i_fmt_blk_len,
    output logic                            o_fmt_done,
    output logic                            o_fmt_err,
    output logic                            o_wipe,
    output logic [1:0]                      o_pi_type,
    output logic [LEN_W-1:0]                o_blk_len,
    output logic [CAP_W-1:0]                o_cap_blocks,
    input  wire logic                       i_cmd_req,
    input  wire logic [1:0]                 i_cmd_cdb,
    input  wire logic                       i_cmd_write,
    input  wire logic [pif_pkg::PROT_W-1:0] i_cmd_protect,
    input  wire logic [CNT_W-1:0]           i_cmd_blocks,
    output logic                            o_cmd_ack,
    output logic                            o_cmd_nak,
    output logic                            o_cmd_done,
    output logic                            o_busy,
    output logic                            o_host_pi,
    output logic                            o_check_en,
    input  wire logic                       i_hw_valid,
    input  wire logic [7:0]                 i_hw_data,
    output logic                            o_hw_ready,
    output logic                            o_mw_valid,
    output logic [7:0]                      o_mw_data,
    input  wire logic                       i_mw_ready,
    input  wire logic                       i_mr_valid,
    input  wire logic [7:0]                 i_mr_data,
    output logic                            o_mr_ready,
    output logic                            o_hr_valid,
    output logic [7:0]                      o_hr_data,
    input  wire logic                       i_hr_ready
);
    import pif_pkg::*;

    pif_state_t       state_reg, state_next;
    logic [1:0]       type_reg;
    logic [LEN_W-1:0] len_reg;
    logic             chk_ok, chk_host_pi, chk_media_pi, chk_check_en;
    logic             wr_done, rd_done;
    logic             write_reg, media_pi_reg;

    // Screen the offered command against the formatted type.
    pif_cmd_check u_check (
        .i_pi_type  (type_reg),
        .i_cdb      (i_cmd_cdb),
        .i_protect  (i_cmd_protect),
        .o_ok       (chk_ok),
        .o_host_pi  (chk_host_pi),
        .o_media_pi (chk_media_pi),
        .o_check_en (chk_check_en)
    );

    // Request decode for format and command in the idle state.
    wire idle      = (state_reg == ST_IDLE);
    wire fmt_take  = i_fmt_req & idle;
    // R11 type 3 refused
    wire fmt_bad   = (i_fmt_type == PI_TYPE3) | (i_fmt_blk_len == '0);
    // R12 wipe on format
    wire fmt_go    = fmt_take & ~fmt_bad;
    wire cmd_seen  = i_cmd_req & ~i_fmt_req;
    wire cmd_go    = cmd_seen & idle & chk_ok;
    wire cmd_zero  = (i_cmd_blocks == '0);
    wire start_xf  = cmd_go & ~cmd_zero;
    wire start_wr  = start_xf & i_cmd_write;
    wire start_rd  = start_xf & ~i_cmd_write;
    wire xfer_end  = (state_reg == ST_XFER) & (write_reg ? wr_done : rd_done);

    // Next command state.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_xf) begin
                    state_next = ST_XFER;
                end
            end
            ST_XFER: begin
                if (xfer_end) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Formatted type, block size and command state.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg    <= ST_IDLE;
            type_reg     <= PI_TYPE0;
            len_reg      <= LEN_W'(DEF_BLK_LEN);
            write_reg    <= 1'b0;
            media_pi_reg <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            // R12 single type held
            // R3 any block size
            if (fmt_go) begin
                type_reg <= i_fmt_type;
                len_reg  <= i_fmt_blk_len;
            end
            if (start_xf) begin
                write_reg    <= i_cmd_write;
                media_pi_reg <= chk_media_pi;
            end
        end
    end

    // Registered status and one-cycle answers.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_fmt_done   <= 1'b0;
            o_fmt_err    <= 1'b0;
            o_wipe       <= 1'b0;
            o_pi_type    <= PI_TYPE0;
            o_blk_len    <= LEN_W'(DEF_BLK_LEN);
            o_cap_blocks <= CAP_W'(CAP_BLOCKS);
            o_cmd_ack    <= 1'b0;
            o_cmd_nak    <= 1'b0;
            o_cmd_done   <= 1'b0;
            o_busy       <= 1'b0;
            o_host_pi    <= 1'b0;
            o_check_en   <= 1'b0;
        end else if (i_ce) begin
            o_fmt_done <= fmt_go;
            // R11 format refused
            o_fmt_err  <= fmt_take & fmt_bad;
            o_wipe     <= fmt_go;
            // R13 type reported
            o_pi_type  <= fmt_go ? i_fmt_type : type_reg;
            o_blk_len  <= fmt_go ? i_fmt_blk_len : len_reg;
            // R2 capacity unchanged
            o_cap_blocks <= CAP_W'(CAP_BLOCKS);
            o_cmd_ack  <= cmd_go;
            // R5 R9 R14 refusals
            o_cmd_nak  <= cmd_seen & ~(idle & chk_ok);
            o_cmd_done <= (cmd_go & cmd_zero) | xfer_end;
            o_busy     <= (state_next == ST_XFER);
            if (cmd_go) begin
                // R6 checks from protect
                o_host_pi  <= chk_host_pi;
                o_check_en <= chk_check_en;
            end
        end
    end

    // R7 write path host PI
    // R10 write path generates PI
    pif_blk_stream #(
        .LEN_W (LEN_W),
        .CNT_W (CNT_W)
    ) u_wr (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_start     (start_wr),
        .i_blk_len   (len_reg),
        .i_blocks    (i_cmd_blocks),
        .i_in_pi     (chk_host_pi),
        .i_out_pi    (chk_media_pi),
        .i_in_valid  (i_hw_valid),
        .i_in_data   (i_hw_data),
        .o_in_ready  (o_hw_ready),
        .o_out_valid (o_mw_valid),
        .o_out_data  (o_mw_data),
        .i_out_ready (i_mw_ready),
        .o_done      (wr_done)
    );

    // R10 read path strips PI
    pif_blk_stream #(
        .LEN_W (LEN_W),
        .CNT_W (CNT_W)
    ) u_rd (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_start     (start_rd),
        .i_blk_len   (len_reg),
        .i_blocks    (i_cmd_blocks),
        .i_in_pi     (chk_media_pi),
        .i_out_pi    (chk_host_pi),
        .i_in_valid  (i_mr_valid),
        .i_in_data   (i_mr_data),
        .o_in_ready  (o_mr_ready),
        .o_out_valid (o_hr_valid),
        .o_out_data  (o_hr_data),
        .i_out_ready (i_hr_ready),
        .o_done      (rd_done)
    );

    // Checks on format handling.
    type3_never_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
        o_pi_type != PI_TYPE3)
        else $error("type 3 reported as formatted");
    fmt3_refused_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
        (i_ce & fmt_take & i_fmt_type == PI_TYPE3) |=> (o_fmt_err & ~o_wipe))
        else $error("type 3 format not refused");
    wipe_on_change_a: assert property (@(posedge i_clk) disable iff (i_rst) // R12
        (i_ce & $changed(type_reg)) |-> o_wipe)
        else $error("type changed without wiping data");
    cap_fixed_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
        o_cap_blocks == CAP_W'(CAP_BLOCKS))
        else $error("capacity moved with format");

    // Checks on command screening.
    type0_prot_nak_a: assert property (@(posedge i_clk) disable iff (i_rst) // R14
        (i_ce & cmd_seen & type_reg == PI_TYPE0 & |i_cmd_protect) |=> (o_cmd_nak & ~o_cmd_ack))
        else $error("type 0 took a protected command");
    type1_long_nak_a: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        (i_ce & cmd_seen & type_reg == PI_TYPE1 & i_cmd_cdb == CDB_32) |=> o_cmd_nak)
        else $error("type 1 took a 32 byte command");
    type2_long_ok_a: assert property (@(posedge i_clk) disable iff (i_rst) // R8
        (i_ce & cmd_seen & idle & type_reg == PI_TYPE2 & i_cmd_cdb == CDB_32) |=> o_cmd_ack)
        else $error("type 2 refused a 32 byte command");
    type2_short_prot_a: assert property (@(posedge i_clk) disable iff (i_rst) // R9
        (i_ce & cmd_seen & type_reg == PI_TYPE2 & i_cmd_cdb != CDB_32 & |i_cmd_protect) |=> o_cmd_nak)
        else $error("type 2 short command with protect taken");
    host_pi_follows_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        (i_ce & cmd_go) |=> (o_host_pi == (type_reg != PI_TYPE0 && $past(|i_cmd_protect))))
        else $error("host PI flag disagrees with command");
    legacy_no_pi_a: assert property (@(posedge i_clk) disable iff (i_rst) // R4
        (state_reg == ST_XFER & type_reg == PI_TYPE0) |-> ~media_pi_reg)
        else $error("type 0 transfer carried PI");

endmodule

// ===== testbench/pif_hba_model.sv
/*
 * Byte-stream peer standing for the host bus adapter; a second copy stands
 * for the media. It sends queued bytes and collects received ones.
 * Assumes one 100 MHz clock and registered valid and ready in the design.
 */
`timescale 1ns/10ps
module pif_hba_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_slow,
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_data,
    input  wire logic       i_tx_ready,
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_data,
    output logic            o_rx_ready
);
    logic [7:0] tx_q[$];
    logic [7:0] rx_q[$];
    logic       took;
    int         seed = 32'h239c;

    // Both sides start idle.
    initial begin
        o_tx_valid = 1'b0;
        o_tx_data  = 8'h00;
        o_rx_ready = 1'b0;
    end

    // Samples at the edge, changes 1 ns later; a byte stays offered until taken.
    // PI bytes kept in order.
    always @(posedge i_clk) begin
        took = o_tx_valid && i_tx_ready;
        if (i_rx_valid && o_rx_ready) begin
            rx_q.push_back(i_rx_data);
        end
        #1;
        if (took) begin
            void'(tx_q.pop_front());
        end
        if (!i_rst && o_tx_valid && !took) begin
            o_tx_valid = 1'b1;
        end else if (!i_rst && tx_q.size() > 0 && (!i_slow || ($random(seed) & 1))) begin
            o_tx_valid = 1'b1;
            o_tx_data  = tx_q[0];
        end else begin
            o_tx_valid = 1'b0;
            o_tx_data  = ~o_tx_data;   // Released data never keeps its old value.
        end
        o_rx_ready = !i_rst && (!i_slow || ($random(seed) & 1));
    end
endmodule

// ===== testbench/tb_pif_pi_formatter.sv
/*
 * Self-checking bench of the protection-information formatter: formats,
 * screens commands and compares both byte streams with a queue model.
 * Assumes the design package and the stream peer model are compiled first.
 */
`timescale 1ns/10ps
module tb_pif_pi_formatter;
    import pif_pkg::*;
    localparam logic [31:0] CAP = 32'h0000_4000;
    logic        i_clk, i_rst, i_ce, i_fmt_req, i_cmd_req, i_cmd_write, slow;
    logic [1:0]  i_fmt_type, i_cmd_cdb, o_pi_type, cur_type;
    logic [15:0] i_fmt_blk_len, i_cmd_blocks, o_blk_len;
    logic [31:0] o_cap_blocks;
    logic [2:0]  i_cmd_protect;
    logic        o_fmt_done, o_fmt_err, o_wipe, o_cmd_ack, o_cmd_nak, o_cmd_done, o_busy, o_host_pi, o_check_en;
    logic        hw_v, hw_r, mw_v, mw_r, mr_v, mr_r, hr_v, hr_r;
    logic [7:0]  hw_d, mw_d, mr_d, hr_d;
    logic [7:0]  exp_q[$];
    int          miscompares, checks, cur_len, t, c, p, w;
    int          seed = 32'h239c;

    pif_pi_formatter #(.CAP_BLOCKS(CAP)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_fmt_req(i_fmt_req), .i_fmt_type(i_fmt_type),
        .i_fmt_blk_len(i_fmt_blk_len), .o_fmt_done(o_fmt_done), .o_fmt_err(o_fmt_err), .o_wipe(o_wipe),
        .o_pi_type(o_pi_type), .o_blk_len(o_blk_len), .o_cap_blocks(o_cap_blocks), .i_cmd_req(i_cmd_req),
        .i_cmd_cdb(i_cmd_cdb), .i_cmd_write(i_cmd_write), .i_cmd_protect(i_cmd_protect),
        .i_cmd_blocks(i_cmd_blocks), .o_cmd_ack(o_cmd_ack), .o_cmd_nak(o_cmd_nak), .o_cmd_done(o_cmd_done),
        .o_busy(o_busy), .o_host_pi(o_host_pi), .o_check_en(o_check_en), .i_hw_valid(hw_v), .i_hw_data(hw_d),
        .o_hw_ready(hw_r), .o_mw_valid(mw_v), .o_mw_data(mw_d), .i_mw_ready(mw_r), .i_mr_valid(mr_v),
        .i_mr_data(mr_d), .o_mr_ready(mr_r), .o_hr_valid(hr_v), .o_hr_data(hr_d), .i_hr_ready(hr_r));
    pif_hba_model hba (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .o_tx_valid(hw_v), .o_tx_data(hw_d),
        .i_tx_ready(hw_r), .i_rx_valid(hr_v), .i_rx_data(hr_d), .o_rx_ready(hr_r));
    pif_hba_model media (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .o_tx_valid(mr_v), .o_tx_data(mr_d),
        .i_tx_ready(mr_r), .i_rx_valid(mw_v), .i_rx_data(mw_d), .o_rx_ready(mw_r));

    // Counts a comparison and reports a mismatch.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", name, expv, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Format request with a competing command in the same cycle.
    task automatic fmt(input logic [1:0] ty, input logic [15:0] len);
        logic ok;
        ok = (ty != PI_TYPE3) && (len != 16'h0000);
        i_fmt_req = 1'b1;
        i_fmt_type = ty;
        i_fmt_blk_len = len;
        i_cmd_req = 1'b1;
        i_cmd_cdb = CDB_10;
        i_cmd_protect = 3'h0;
        i_cmd_blocks = 16'h0000;
        @(posedge i_clk) #1;
        i_fmt_req = 1'b0;
        i_cmd_req = 1'b0;
        if (ok) begin
            cur_type = ty;
            cur_len = len;
        end
        check("fmt_done", o_fmt_done, ok);
        check("fmt_err", o_fmt_err, !ok);
        check("wipe", o_wipe, ok);
        check("pi_type", o_pi_type, cur_type);
        check("blk_len", o_blk_len, cur_len);
        check("cap_blocks", o_cap_blocks, CAP);
        check("cmd_answer", {o_cmd_ack, o_cmd_nak}, 0);
        @(posedge i_clk) #1;
    endtask

    // One command: builds the expected stream, runs it and compares.
    task automatic do_cmd(input logic [1:0] cdb, input logic wr, input logic [2:0] pr, input int nb);
        logic       ok, hpi, mpi;
        logic [7:0] d;
        logic [7:0] got[$];
        int         k;
        ok = cdb != CDB_OTHER && !(cur_type == PI_TYPE0 && (cdb == CDB_32 || pr != 0))
             && !(cur_type == PI_TYPE1 && cdb == CDB_32) && !(cur_type == PI_TYPE2 && cdb != CDB_32 && pr != 0);
        hpi = ok && pr != 0;
        mpi = cur_type != PI_TYPE0;
        hba.rx_q.delete();
        media.rx_q.delete();
        exp_q.delete();
        for (int b = 0; ok && b < nb; b++) begin
            for (k = 0; k < cur_len + 8; k++) begin
                d = $random(seed);
                if (k < cur_len || (wr ? hpi : mpi)) begin
                    if (wr) hba.tx_q.push_back(d);
                    else media.tx_q.push_back(d);
                end
                if (k < cur_len || hpi) exp_q.push_back(d);
                else if (wr && mpi) exp_q.push_back(PI_FILL);
            end
        end
        slow = $random(seed) & 1;
        i_cmd_req = 1'b1;
        i_cmd_cdb = cdb;
        i_cmd_write = wr;
        i_cmd_protect = pr;
        i_cmd_blocks = nb[15:0];
        @(posedge i_clk) #1;
        i_cmd_req = 1'b0;
        check("cmd_ack", o_cmd_ack, ok);
        check("cmd_nak", o_cmd_nak, !ok);
        if (ok) begin
            check("host_pi", o_host_pi, hpi);
            check("check_en", o_check_en, hpi);
            for (k = 0; k < 20000 && o_cmd_done !== 1'b1; k++) @(posedge i_clk) #1;
            if (k == 20000) begin
                miscompares++;
                complete_run();
            end
            // The last byte may still sit in the output stage when done pulses.
            for (k = 0; k < 64 && hba.rx_q.size() + media.rx_q.size() < exp_q.size(); k++) @(posedge i_clk) #1;
            if (wr) got = media.rx_q;
            else got = hba.rx_q;
            check("busy", o_busy, 0);
            check("stream_len", got.size(), exp_q.size());
            foreach (exp_q[i]) check("stream_byte", got[i], exp_q[i]);
        end
        @(posedge i_clk) #1;
    endtask

    // Free-running 100 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Reset, refused formats, then types 0 to 2 with every length code, direction and protect case.
    initial begin
        {i_rst, i_ce, i_fmt_req, i_cmd_req, i_cmd_write, slow} = 6'b110000;
        {i_fmt_type, i_cmd_cdb, i_cmd_protect, i_fmt_blk_len, i_cmd_blocks} = '0;
        miscompares = 0;
        checks = 0;
        cur_type = PI_TYPE0;
        cur_len = DEF_BLK_LEN;
        repeat (3) @(posedge i_clk);
        #1 i_rst = 1'b0;
        check("pi_type", o_pi_type, PI_TYPE0);
        check("blk_len", o_blk_len, DEF_BLK_LEN);
        fmt(PI_TYPE3, 16'h0004);
        fmt(PI_TYPE1, 16'h0000);
        for (t = 0; t < 3; t++) begin
            fmt(t[1:0], 16'(4 * t + 4));
            for (c = 0; c < 4; c++)
                for (w = 0; w < 2; w++)
                    for (p = 0; p < 2; p++)
                        do_cmd(c[1:0], w[0], p ? 3'(($random(seed) & 7) | 1) : 3'h0, (c == 0 && w) ? 0 : 2);
        end
        fmt(PI_TYPE1, DEF_BLK_LEN);
        do_cmd(CDB_16, 1'b1, 3'h1, 1);
        do_cmd(CDB_16, 1'b0, 3'h1, 1);
        // A format offered while the clock enable is low must leave the type alone.
        i_ce = 1'b0;
        i_fmt_req = 1'b1;
        i_fmt_type = PI_TYPE2;
        @(posedge i_clk) #1;
        check("ce_hold", {o_fmt_done, o_pi_type}, {1'b0, cur_type});
        i_fmt_req = 1'b0;
        i_ce = 1'b1;
        @(posedge i_clk) #1;
        check("ce_resume", {o_fmt_done, o_pi_type}, {1'b0, cur_type});
        complete_run();
    end
endmodule
